// File: hw/drive_state_status_machine.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
module drive_state_status_machine #(
  parameter int unsigned BLINK_CYCLES =
    drive_state_pkg::CLK_HZ / 1000 * drive_state_pkg::BLINK_MS
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // sense pins, asynchronous
  input  wire logic                        dc_bus_sense,
  input  wire logic                        fault_sense,
  input  wire logic                        power_ok_sense,
  // indicators and drive control
  output logic                             dc_bus_lamp,
  output logic [7:0]                       seg_out,
  output drive_state_pkg::drive_out_s      drive_ctl
);

  // digit shown for each state
  function automatic logic [3:0] code_of(input drive_state_pkg::dstate_e s);
    unique case (s)
      drive_state_pkg::ST_INIT:   code_of = 4'h1;
      drive_state_pkg::ST_NRDY:   code_of = 4'h2;
      drive_state_pkg::ST_SWDIS:  code_of = 4'h3;
      drive_state_pkg::ST_READY:  code_of = 4'h4;
      drive_state_pkg::ST_OPER:   code_of = 4'h6;
      drive_state_pkg::ST_QSTOP:  code_of = 4'h7;
      drive_state_pkg::ST_FREACT: code_of = 4'h8;
      drive_state_pkg::ST_FAULT:  code_of = 4'h9;
      default:                    code_of = 4'hF;
    endcase
  endfunction : code_of

  // segment pattern {dp,g,f,e,d,c,b,a}, active high
  function automatic logic [7:0] seg_of(input logic [3:0] v);
    case (v)
      4'h0:    seg_of = 8'h3F;
      4'h1:    seg_of = 8'h06;
      4'h2:    seg_of = 8'h5B;
      4'h3:    seg_of = 8'h4F;
      4'h4:    seg_of = 8'h66;
      4'h5:    seg_of = 8'h6D;
      4'h6:    seg_of = 8'h7D;
      4'h7:    seg_of = 8'h07;
      4'h8:    seg_of = 8'h7F;
      4'h9:    seg_of = 8'h6F;
      4'hA:    seg_of = 8'h77;
      default: seg_of = 8'h40;
    endcase
  endfunction : seg_of

  drive_state_pkg::regs_s state_r;
  drive_state_pkg::regs_s state_nxt;

  logic        wr_acc;
  logic        rd_acc;
  logic        motor_ok;
  logic [3:0]  err_val;

  // apb access completes in the cycle where pready is high
  assign wr_acc   = psel && penable && pwrite && state_r.pready;
  assign rd_acc   = psel && penable && !pwrite && state_r.pready;
  assign motor_ok = !state_r.cfg[drive_state_pkg::CFG_RESOLVER]
                    || state_r.cfg[drive_state_pkg::CFG_LOADED];
  assign err_val  = state_r.cfg[drive_state_pkg::CFG_ERR_LSB +: 4];

  // next state of the whole block
  always_comb begin
    state_nxt = state_r;

    // three-stage synchronisers; a change counts once stages 2 and 3 agree
    state_nxt.s_dc  = {state_r.s_dc[1:0], dc_bus_sense};
    state_nxt.s_flt = {state_r.s_flt[1:0], fault_sense};
    state_nxt.s_pwr = {state_r.s_pwr[1:0], power_ok_sense};
    if (state_r.s_dc[2] == state_r.s_dc[1]) begin
      state_nxt.dc = state_r.s_dc[2];
    end
    if (state_r.s_flt[2] == state_r.s_flt[1]) begin
      state_nxt.flt = state_r.s_flt[2];
    end
    if (state_r.s_pwr[2] == state_r.s_pwr[1]) begin
      state_nxt.pwr = state_r.s_pwr[2];
    end

    // apb: one wait state, pready pulses for one cycle
    state_nxt.pready  = psel && penable && !state_r.pready;
    state_nxt.pslverr = 1'b0;
    if (psel && penable && !state_r.pready) begin
      state_nxt.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          drive_state_pkg::CMD_OFS:  state_nxt.prdata = {16'h0000, state_r.cmd};
          drive_state_pkg::STAT_OFS: state_nxt.prdata =
            {16'h0000, state_r.dc, state_r.flt, state_r.pwr, motor_ok,
             code_of(state_r.st), state_r.st};
          drive_state_pkg::CFG_OFS:  state_nxt.prdata = {24'h00_0000, state_r.cfg};
          default:                   state_nxt.pslverr = 1'b1;
        endcase
      end else begin
        state_nxt.pslverr = !(paddr inside {drive_state_pkg::CMD_OFS,
                                            drive_state_pkg::CFG_OFS});
      end
    end

    // register writes; a command write queues exactly one pass
    state_nxt.pass = 1'b0;
    if (wr_acc && paddr == drive_state_pkg::CMD_OFS) begin
      state_nxt.cmd  = pwdata[15:0];
      state_nxt.pass = 1'b1;
    end
    if (wr_acc && paddr == drive_state_pkg::CFG_OFS) begin
      state_nxt.cfg = pwdata[7:0];
    end

    // state timer counts down, zero means expired
    if (state_r.tmr != 12'h000) begin
      state_nxt.tmr = state_r.tmr - 12'h001;
    end

    // operating state machine; a detected fault beats any command
    unique case (state_r.st)
      drive_state_pkg::ST_INIT: begin
        if (state_r.tmr == 12'h000) begin
          state_nxt.st = drive_state_pkg::ST_NRDY;
        end
      end
      drive_state_pkg::ST_NRDY: begin
        if (state_r.flt) begin
          state_nxt.st  = drive_state_pkg::ST_FREACT;
          // timer leaves on zero, so load one less for the full reaction time
          state_nxt.tmr = 12'(drive_state_pkg::REACT_CYCLES - 1);
        end else if (state_r.pwr) begin
          state_nxt.st = drive_state_pkg::ST_SWDIS;
        end
      end
      drive_state_pkg::ST_FREACT: begin
        if (state_r.tmr == 12'h000) begin
          state_nxt.st = drive_state_pkg::ST_FAULT;
        end
      end
      drive_state_pkg::ST_FAULT: begin
        // clear only takes once the cause is gone
        if (state_r.pass && state_r.cmd[drive_state_pkg::CMD_FCLEAR]
            && !state_r.flt) begin
          state_nxt.st = drive_state_pkg::ST_SWDIS;
        end
      end
      default: begin
        if (state_r.flt) begin
          state_nxt.st  = drive_state_pkg::ST_FREACT;
          state_nxt.tmr = 12'(drive_state_pkg::REACT_CYCLES - 1);
        end else if (!state_r.pwr) begin
          // losing stage supply drops back to not ready
          state_nxt.st = drive_state_pkg::ST_NRDY;
        end else if (state_r.pass) begin
          // priority: disable, quick stop, release, halt, enable
          if (state_r.cmd[drive_state_pkg::CMD_DISABLE]) begin
            state_nxt.st = drive_state_pkg::ST_SWDIS;
          end else if (state_r.cmd[drive_state_pkg::CMD_QSTOP]) begin
            if (state_r.st == drive_state_pkg::ST_OPER) begin
              state_nxt.st = drive_state_pkg::ST_QSTOP;
            end
          end else if (state_r.cmd[drive_state_pkg::CMD_QREL]) begin
            if (state_r.st == drive_state_pkg::ST_QSTOP) begin
              state_nxt.st = drive_state_pkg::ST_OPER;
            end
          end else if (state_r.cmd[drive_state_pkg::CMD_HALT]) begin
            if (state_r.st == drive_state_pkg::ST_OPER) begin
              state_nxt.drv.motion_halt = 1'b1;
            end
          end else if (state_r.cmd[drive_state_pkg::CMD_ENABLE]) begin
            if (state_r.st == drive_state_pkg::ST_SWDIS && motor_ok) begin
              state_nxt.st = drive_state_pkg::ST_READY;
            end else if (state_r.st == drive_state_pkg::ST_READY) begin
              state_nxt.st = drive_state_pkg::ST_OPER;
            end else if (state_r.st == drive_state_pkg::ST_OPER) begin
              state_nxt.drv.motion_halt = 1'b0;
            end
          end
        end
      end
    endcase

    // drive outputs follow the new state
    state_nxt.drv.power_en = state_nxt.st inside {drive_state_pkg::ST_OPER,
                                                  drive_state_pkg::ST_QSTOP};
    state_nxt.drv.quick_stop = state_nxt.st == drive_state_pkg::ST_QSTOP;
    if (state_nxt.st != drive_state_pkg::ST_OPER) begin
      state_nxt.drv.motion_halt = 1'b0;
    end

    // blink divider, a full period every two terminal counts
    if (state_r.blk >= BLINK_CYCLES - 1) begin
      state_nxt.blk   = 32'h0000_0000;
      state_nxt.phase = !state_r.phase;
    end else begin
      state_nxt.blk = state_r.blk + 32'h0000_0001;
    end

    // display follows the new state so code and state line up
    if (state_nxt.cfg[drive_state_pkg::CFG_ERR_SHOW]) begin
      // new digit at once, so a config write never shows a stale value
      state_nxt.seg = state_nxt.phase ?
                      seg_of(state_nxt.cfg[drive_state_pkg::CFG_ERR_LSB +: 4]) : 8'h00;
    end else begin
      state_nxt.seg = seg_of(code_of(state_nxt.st));
      if (state_nxt.st inside {drive_state_pkg::ST_FREACT,
                               drive_state_pkg::ST_FAULT}) begin
        state_nxt.seg[7] = 1'b1;
      end
    end
  end

  // the one register of the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '{st: drive_state_pkg::ST_INIT,
                   cmd: drive_state_pkg::CMD_RST,
                   cfg: drive_state_pkg::CFG_RST,
                   tmr: 12'(drive_state_pkg::INIT_CYCLES - 1),
                   seg: drive_state_pkg::SEG_RST,
                   default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the register
  assign pready      = state_r.pready;
  assign prdata      = state_r.prdata;
  assign pslverr     = state_r.pslverr;
  assign dc_bus_lamp = state_r.dc;
  assign seg_out     = state_r.seg;
  assign drive_ctl   = state_r.drv;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic show;
  assign show = state_r.cfg[drive_state_pkg::CFG_ERR_SHOW];

  property p_code_init;
    (state_r.st == drive_state_pkg::ST_INIT) && !show |-> seg_out == 8'h06;
  endproperty
  a_code_init: assert property (p_code_init) else $error("init code wrong");

  property p_code_nrdy;
    (state_r.st == drive_state_pkg::ST_NRDY) && !show |-> seg_out == 8'h5B;
  endproperty
  a_code_nrdy: assert property (p_code_nrdy) else $error("code 2 wrong");

  property p_code_swdis;
    (state_r.st == drive_state_pkg::ST_SWDIS) && !show |-> seg_out == 8'h4F;
  endproperty
  a_code_swdis: assert property (p_code_swdis) else $error("code 3 wrong");

  property p_code_ready;
    (state_r.st == drive_state_pkg::ST_READY) && !show |-> seg_out == 8'h66;
  endproperty
  a_code_ready: assert property (p_code_ready) else $error("code 4 wrong");

  property p_code_oper;
    (state_r.st == drive_state_pkg::ST_OPER) && !show
      |-> seg_out == 8'h7D && drive_ctl.power_en;
  endproperty
  a_code_oper: assert property (p_code_oper) else $error("code 6 wrong");

  property p_code_qstop;
    (state_r.st == drive_state_pkg::ST_QSTOP) && !show
      |-> seg_out == 8'h07 && drive_ctl.quick_stop;
  endproperty
  a_code_qstop: assert property (p_code_qstop) else $error("code 7 wrong");

  property p_fault_seq;
    $rose(state_r.st == drive_state_pkg::ST_FREACT) && !show
      |-> seg_out == 8'hFF ##[1:1000] state_r.st == drive_state_pkg::ST_FAULT;
  endproperty
  a_fault_seq: assert property (p_fault_seq) else $error("fault sequence wrong");

  property p_flash;
    show |-> seg_out == (state_r.phase ? seg_of(err_val) : 8'h00);
  endproperty
  a_flash: assert property (p_flash) else $error("error digit not flashing");

  property p_pass;
    wr_acc && paddr == drive_state_pkg::CMD_OFS
      |=> state_r.pass && state_r.cmd == $past(pwdata[15:0]) ##1 !state_r.pass;
  endproperty
  a_pass: assert property (p_pass) else $error("command write missed");

  property p_lamp;
    state_r.s_dc[2] == state_r.s_dc[1] |=> dc_bus_lamp == $past(state_r.s_dc[2]);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp does not follow bus");

  property p_resolver;
    state_r.st == drive_state_pkg::ST_SWDIS && !motor_ok
      |=> state_r.st != drive_state_pkg::ST_READY;
  endproperty
  a_resolver: assert property (p_resolver) else $error("enabled without data");

  property p_prio;
    state_r.pass && state_r.cmd[0] && state_r.pwr && !state_r.flt
      && state_r.st inside {drive_state_pkg::ST_READY, drive_state_pkg::ST_OPER}
      |=> state_r.st == drive_state_pkg::ST_SWDIS;
  endproperty
  a_prio: assert property (p_prio) else $error("disable lost priority");

endmodule : drive_state_status_machine

// File: hw/drive_state_pkg.sv
package drive_state_pkg;

  // register byte offsets
  localparam logic [11:0] CMD_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] CFG_OFS  = 12'h008;

  // command word bit positions
  localparam int CMD_DISABLE = 0;
  localparam int CMD_ENABLE  = 1;
  localparam int CMD_QSTOP   = 2;
  localparam int CMD_FCLEAR  = 3;
  localparam int CMD_QREL    = 4;
  localparam int CMD_HALT    = 5;

  // configuration bit positions
  localparam int CFG_LOADED   = 0;
  localparam int CFG_RESOLVER = 1;
  localparam int CFG_ERR_SHOW = 2;
  localparam int CFG_ERR_LSB  = 4;

  // reset values
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [7:0]  CFG_RST = 8'h00;
  localparam logic [7:0]  SEG_RST = 8'h06; // code 1 while initialising

  // timing
  localparam int CLK_HZ      = 20000000;
  localparam int INIT_US     = 100;
  localparam int REACT_US    = 50;
  localparam int BLINK_MS    = 250;
  localparam int INIT_CYCLES  = INIT_US * (CLK_HZ / 1000000);
  localparam int REACT_CYCLES = REACT_US * (CLK_HZ / 1000000);

  // operating states, one-hot
  typedef enum logic [7:0] {
    ST_INIT   = 8'h01,
    ST_NRDY   = 8'h02,
    ST_SWDIS  = 8'h04,
    ST_READY  = 8'h08,
    ST_OPER   = 8'h10,
    ST_QSTOP  = 8'h20,
    ST_FREACT = 8'h40,
    ST_FAULT  = 8'h80
  } dstate_e;

  // power stage control towards the drive
  typedef struct packed {
    logic power_en;
    logic quick_stop;
    logic motion_halt;
  } drive_out_s;

  // whole state of the block
  typedef struct packed {
    dstate_e     st;
    logic [15:0] cmd;
    logic        pass;
    logic [7:0]  cfg;
    logic [2:0]  s_dc;
    logic [2:0]  s_flt;
    logic [2:0]  s_pwr;
    logic        dc;
    logic        flt;
    logic        pwr;
    logic [11:0] tmr;
    logic [31:0] blk;
    logic        phase;
    logic [7:0]  seg;
    drive_out_s  drv;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } regs_s;

endpackage : drive_state_pkg

// File: verification/drive_state_status_machine_test.sv
module drive_state_status_machine_test;
  timeunit 1ns;
  timeprecision 1ps;

  // one expected apb answer, noted by the driver
  typedef struct packed {
    logic        rd;
    logic [31:0] data;
    logic        err;
  } note_s;

  logic                        pclk;
  logic                        presetn;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata;
  logic                        pready;
  logic [31:0]                 prdata;
  logic                        pslverr;
  logic                        dc_bus_sense;
  logic                        fault_sense;
  logic                        power_ok_sense;
  logic                        dc_bus_lamp;
  logic [7:0]                  seg_out;
  drive_state_pkg::drive_out_s drive_ctl;
  note_s                       notes[$];
  int                          n_errors;
  int                          comparisons;
  int                          seed;
  int                          n_digit;
  int                          n_blank;
  int                          n_other;

  // short blink period keeps the flashing check brief
  drive_state_status_machine #(.BLINK_CYCLES(4)) i_drive_state_status_machine (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pready         (pready),
    .prdata         (prdata),
    .pslverr        (pslverr),
    .dc_bus_sense   (dc_bus_sense),
    .fault_sense    (fault_sense),
    .power_ok_sense (power_ok_sense),
    .dc_bus_lamp    (dc_bus_lamp),
    .seg_out        (seg_out),
    .drive_ctl      (drive_ctl)
  );

  // 20 mhz clock
  always #25 pclk = ~pclk;

  task oops(input string msg);
    n_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : oops

  task tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task cmp_apb(input note_s n);
    comparisons++;
    if (pslverr !== n.err || (n.rd && prdata !== n.data)) begin
      oops($sformatf("apb answer %h/%b, wanted %h/%b", prdata, pslverr, n.data, n.err));
    end
  endtask : cmp_apb

  task chk_seg(input logic [7:0] e);
    comparisons++;
    if (seg_out !== e) begin
      oops($sformatf("display %h, wanted %h", seg_out, e));
    end
  endtask : chk_seg

  task chk_bit(input logic a, input logic e, input string what);
    comparisons++;
    if (a !== e) begin
      oops($sformatf("%s is %b, wanted %b", what, a, e));
    end
  endtask : chk_bit

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one apb transfer; waits for pready under a bound, never a fixed count
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    notes.push_back('{rd: !w, data: ed, err: ee});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      oops("no ready from slave");
      tally_and_finish();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // command write; upper half is random noise the block must ignore
  task wr_cmd(input logic [15:0] c);
    logic [31:0] r;
    r = $random(seed);
    apb(1'b1, drive_state_pkg::CMD_OFS, {r[31:16], c}, 32'h0000_0000, 1'b0);
    cyc(3);
  endtask : wr_cmd

  // answer watcher: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        oops("answer without a request");
      end else begin
        cmp_apb(notes.pop_front());
      end
    end
  end

  // guard against a hang anywhere in the sequence
  initial begin
    cyc(100000);
    oops("run took too long");
    tally_and_finish();
  end

  initial begin
    seed           = 53570;
    pclk           = 1'b0;
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0000_0000;
    dc_bus_sense   = 1'b0;
    fault_sense    = 1'b0;
    power_ok_sense = 1'b0;
    cyc(12);
    chk_seg(8'h06);
    chk_bit(dc_bus_lamp, 1'b0, "lamp in reset");
    presetn <= 1'b1;
    apb(1'b0, drive_state_pkg::CMD_OFS, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, drive_state_pkg::CFG_OFS, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h00C, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, drive_state_pkg::STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    chk_seg(8'h06);
    $display("test reset and init done");
    // power stage supply absent after init, then present
    cyc(2000);
    chk_seg(8'h5B);
    power_ok_sense <= 1'b1;
    cyc(10);
    chk_seg(8'h4F);
    for (int i = 0; i < 3; i++) begin
      dc_bus_sense <= (i != 1);
      cyc(8);
      chk_bit(dc_bus_lamp, (i != 1), "lamp");
    end
    $display("test supply and lamp done");
    // resolver without motor data must not reach ready
    apb(1'b1, drive_state_pkg::CFG_OFS, 32'h0000_0002, 32'h0, 1'b0);
    wr_cmd(16'h0002);
    chk_seg(8'h4F);
    apb(1'b1, drive_state_pkg::CFG_OFS, 32'h0000_0003, 32'h0, 1'b0);
    wr_cmd(16'h0002);
    chk_seg(8'h66);
    wr_cmd(16'h0002);
    chk_seg(8'h7D);
    chk_bit(drive_ctl.power_en, 1'b1, "power enable");
    wr_cmd(16'h0003);
    chk_seg(8'h4F);
    wr_cmd(16'h0002);
    wr_cmd(16'h0002);
    wr_cmd(16'h0006);
    chk_seg(8'h07);
    chk_bit(drive_ctl.quick_stop, 1'b1, "quick stop");
    wr_cmd(16'h0010);
    chk_seg(8'h7D);
    wr_cmd(16'h0020);
    chk_bit(drive_ctl.motion_halt, 1'b1, "halt");
    wr_cmd(16'hFFC0);
    chk_seg(8'h7D);
    chk_bit(drive_ctl.motion_halt, 1'b1, "halt kept");
    apb(1'b0, drive_state_pkg::CMD_OFS, 32'h0, 32'h0000_FFC0, 1'b0);
    wr_cmd(16'h0002);
    chk_bit(drive_ctl.motion_halt, 1'b0, "halt cleared");
    $display("test commands done");
    // fault: reaction code, then fault code; clear refused while fault stands
    fault_sense <= 1'b1;
    cyc(8);
    chk_seg(8'hFF);
    cyc(1010);
    chk_seg(8'hEF);
    wr_cmd(16'h0008);
    chk_seg(8'hEF);
    fault_sense <= 1'b0;
    cyc(8);
    wr_cmd(16'h0008);
    chk_seg(8'h4F);
    apb(1'b0, drive_state_pkg::STAT_OFS, 32'h0, 32'h0000_B304, 1'b0);
    // stage supply lost and back: not ready, then disabled again
    power_ok_sense <= 1'b0;
    cyc(8);
    chk_seg(8'h5B);
    power_ok_sense <= 1'b1;
    cyc(8);
    chk_seg(8'h4F);
    $display("test fault done");
    // error digit a flashing against blank
    apb(1'b1, drive_state_pkg::CFG_OFS, 32'h0000_00A7, 32'h0, 1'b0);
    apb(1'b0, drive_state_pkg::CFG_OFS, 32'h0, 32'h0000_00A7, 1'b0);
    n_digit = 0;
    n_blank = 0;
    n_other = 0;
    repeat (16) begin
      @(posedge pclk);
      if (seg_out === 8'h77) n_digit++;
      else if (seg_out === 8'h00) n_blank++;
      else n_other++;
    end
    chk_bit(n_digit > 0 && n_blank > 0 && n_other == 0, 1'b1, "flashing");
    $display("test flashing done");
    tally_and_finish();
  end
endmodule : drive_state_status_machine_test
